// [logic/cartesian_polar_converter.sv]
// iterative cartesian to polar converter, magnitude and phase per i/q pair
//
// How it works
// - takes 16-bit signed i and q, computes vector magnitude and phase
// - phase is 18 bits truncated; top 16 to formatter, all 18 to discriminator
// - 16-bit phase reads as signed -0.5..0.5 or unsigned 0..1 turn
// - one revolution spans the full word; msb weighs 180 degrees
// - magnitude is 16-bit unsigned, 0 to 2.32, msb always zero
// - magnitude keeps the 1.64676 rotation gain, not compensated
// - magnitude bit 15 weighs 2^2 and is zero, bit 0 weighs 2^-13
// - full precision takes 17 cycles, then result goes to holding register
// - a new sample before 17 cycles latches the partial result, then restarts
// - each extra cycle halves the phase error, down to 0.00175 degrees
// - discriminator port carries the full 18-bit phase
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defs.svh"

module cartesian_polar_converter
  import cpc_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic                     in_valid,
  input  wire sample_s                  in_sample,
  output var  polar_s                   result,
  output var  logic [`CPC_PH_FMT_W-1:0] phase_fmt,
  output var  logic                     result_valid
);

  // arctan table lookup, used by every iteration step
  function automatic logic [`CPC_PH_W-1:0] atan_of(
    input logic [`CPC_CNT_W-1:0] k
  );
    logic [`CPC_PH_W-1:0] v;
    v = `CPC_PH_RST;
    case (k)
      5'h00:   v = `CPC_ATAN_0;
      5'h01:   v = `CPC_ATAN_1;
      5'h02:   v = `CPC_ATAN_2;
      5'h03:   v = `CPC_ATAN_3;
      5'h04:   v = `CPC_ATAN_4;
      5'h05:   v = `CPC_ATAN_5;
      5'h06:   v = `CPC_ATAN_6;
      5'h07:   v = `CPC_ATAN_7;
      5'h08:   v = `CPC_ATAN_8;
      5'h09:   v = `CPC_ATAN_9;
      5'h0A:   v = `CPC_ATAN_10;
      5'h0B:   v = `CPC_ATAN_11;
      5'h0C:   v = `CPC_ATAN_12;
      5'h0D:   v = `CPC_ATAN_13;
      5'h0E:   v = `CPC_ATAN_14;
      5'h0F:   v = `CPC_ATAN_15;
      default: v = `CPC_PH_RST;
    endcase
    return v;
  endfunction : atan_of

  // accumulator x to held magnitude: drop two fraction bits
  function automatic logic [`CPC_MAG_W-1:0] mag_of(
    input logic signed [`CPC_ACC_W-1:0] x
  );
    logic [`CPC_ACC_W-1:0] s;
    s = `CPC_ACC_RST;
    s = x >>> `CPC_MAG_SHIFT;
    // top bit forced low, keeps unsigned 0..2.32 range
    return {1'b0, s[`CPC_MAG_W-2:0]};
  endfunction : mag_of

  conv_state_e                     state_ff;
  conv_state_e                     nxt_state;
  logic signed [`CPC_ACC_W-1:0]    x_ff;
  logic signed [`CPC_ACC_W-1:0]    nxt_x;
  logic signed [`CPC_ACC_W-1:0]    y_ff;
  logic signed [`CPC_ACC_W-1:0]    nxt_y;
  logic [`CPC_PH_W-1:0]            z_ff;
  logic [`CPC_PH_W-1:0]            nxt_z;
  logic [`CPC_CNT_W-1:0]           iter_ff;
  logic [`CPC_CNT_W-1:0]           nxt_iter;

  polar_s                          result_ff;
  polar_s                          nxt_result;
  logic                            strobe_ff;
  logic                            nxt_strobe;

  // one refinement step values
  logic signed [`CPC_ACC_W-1:0]    step_x;
  logic signed [`CPC_ACC_W-1:0]    step_y;
  logic [`CPC_PH_W-1:0]            step_z;
  logic signed [`CPC_ACC_W-1:0]    sh_x;
  logic signed [`CPC_ACC_W-1:0]    sh_y;

  // coarse rotation of the incoming sample
  logic signed [`CPC_ACC_W-1:0]    load_x;
  logic signed [`CPC_ACC_W-1:0]    load_y;
  logic [`CPC_PH_W-1:0]            load_z;
  logic signed [`CPC_ACC_W-1:0]    ext_i;
  logic signed [`CPC_ACC_W-1:0]    ext_q;

  logic                            last_step;
  logic [`CPC_PH_W-1:0]            atan_now;
  logic                            step_dir;
  logic [`CPC_PH_W-1:0]            atan_rom [`CPC_N_ITER];

  // capture sources for the holding register
  logic                            cap_full;
  logic                            cap_partial;
  logic [`CPC_MAG_W-1:0]           cap_mag;
  logic [`CPC_PH_W-1:0]            cap_phase;
  logic [`CPC_CNT_W-1:0]           cap_depth;
  logic [`CPC_PH_FMT_W-1:0]        phase_fmt_ff;
  logic [`CPC_PH_FMT_W-1:0]        nxt_phase_fmt;

  // arctan table, one entry per refinement step
  for (genvar g = 0; g < `CPC_N_ITER; g++) begin : g_atan
    assign atan_rom[g] = atan_of(`CPC_CNT_W'(g));
  end

  // sign extension of inputs into the wider accumulators
  always_comb begin
    ext_i = `CPC_ACC_W'(in_sample.in_i);
    ext_q = `CPC_ACC_W'(in_sample.in_q);
  end

  // left half plane folded over by a half turn, first cycle of 17
  always_comb begin
    load_x = ext_i;
    load_y = ext_q;
    load_z = `CPC_PH_RST;
    if (ext_i < 0) begin
      load_x = -ext_i;
      load_y = -ext_q;
      load_z = `CPC_HALF_TURN;
    end
  end

  // vectoring step: drive y toward zero, gather angle in z
  always_comb begin
    atan_now = atan_rom[iter_ff[`CPC_CNT_W-2:0]];
    step_dir = (y_ff >= 0);
    sh_x     = x_ff >>> iter_ff;
    sh_y     = y_ff >>> iter_ff;
    step_x   = x_ff;
    step_y   = y_ff;
    step_z   = z_ff;
    if (step_dir) begin
      step_x = x_ff + sh_y;
      step_y = y_ff - sh_x;
      step_z = z_ff + atan_now;
    end else begin
      step_x = x_ff - sh_y;
      step_y = y_ff + sh_x;
      step_z = z_ff - atan_now;
    end
  end

  assign last_step = (state_ff == ST_RUN) && (iter_ff == `CPC_LAST_ITER);

  // which result, if any, is captured at this edge
  always_comb begin
    // the last step wins over a sample landing on the same edge
    cap_full    = last_step;
    cap_partial = in_valid && (state_ff == ST_RUN) && !last_step;
    // preempted: what has been refined so far, before this edge's step
    cap_mag     = mag_of(x_ff);
    cap_phase   = z_ff;
    cap_depth   = iter_ff + 5'h01;
    if (cap_full) begin
      // seventeenth cycle, full precision
      cap_mag   = mag_of(step_x);
      cap_phase = step_z;
      cap_depth = `CPC_FULL_CYCLES;
    end
  end

  // control group: sequencing state and iteration count
  always_comb begin
    nxt_state = state_ff;
    nxt_iter  = iter_ff;
    case (state_ff)
      ST_IDLE: begin
        if (in_valid) begin
          nxt_iter  = `CPC_CNT_RST;
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (in_valid) begin
          // a new sample restarts the count wherever the old one stood
          nxt_iter  = `CPC_CNT_RST;
          nxt_state = ST_RUN;
        end else if (last_step) begin
          nxt_iter  = `CPC_CNT_RST;
          nxt_state = ST_IDLE;
        end else begin
          nxt_iter  = iter_ff + 5'h01;
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_iter  = `CPC_CNT_RST;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      iter_ff  <= `CPC_CNT_RST;
    end else begin
      state_ff <= nxt_state;
      iter_ff  <= nxt_iter;
    end
  end

  // datapath group: load a new sample or take one refinement step
  always_comb begin
    nxt_x = x_ff;
    nxt_y = y_ff;
    nxt_z = z_ff;
    case (state_ff)
      ST_IDLE: begin
        if (in_valid) begin
          nxt_x = load_x;
          nxt_y = load_y;
          nxt_z = load_z;
        end
      end
      ST_RUN: begin
        if (in_valid) begin
          // the old sample is dropped once its partial or full result is held
          nxt_x = load_x;
          nxt_y = load_y;
          nxt_z = load_z;
        end else if (!last_step) begin
          nxt_x = step_x;
          nxt_y = step_y;
          nxt_z = step_z;
        end
      end
      default: begin
        nxt_x = `CPC_ACC_RST;
        nxt_y = `CPC_ACC_RST;
        nxt_z = `CPC_PH_RST;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      x_ff <= `CPC_ACC_RST;
      y_ff <= `CPC_ACC_RST;
      z_ff <= `CPC_PH_RST;
    end else begin
      x_ff <= nxt_x;
      y_ff <= nxt_y;
      z_ff <= nxt_z;
    end
  end

  // result group: holding register, formatter word and update strobe
  always_comb begin
    nxt_result    = result_ff;
    nxt_phase_fmt = phase_fmt_ff;
    nxt_strobe    = 1'b0;
    if (cap_full || cap_partial) begin
      nxt_result.mag   = cap_mag;
      nxt_result.phase = cap_phase;
      nxt_result.depth = cap_depth;
      // formatter word keeps the top bits only, truncated
      nxt_phase_fmt    = cap_phase[`CPC_PH_W-1 -: `CPC_PH_FMT_W];
      nxt_strobe       = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result_ff    <= '0;
      phase_fmt_ff <= '0;
      strobe_ff    <= 1'b0;
    end else begin
      result_ff    <= nxt_result;
      phase_fmt_ff <= nxt_phase_fmt;
      strobe_ff    <= nxt_strobe;
    end
  end

  // held results straight from the holding registers
  always_comb begin
    result       = result_ff;
    phase_fmt    = phase_fmt_ff;
    result_valid = strobe_ff;
  end

endmodule : cartesian_polar_converter

`default_nettype wire

// [logic/cpc_defs.svh]
// constants for the cartesian to polar converter
`ifndef CPC_DEFS_SVH
`define CPC_DEFS_SVH

`define CPC_IN_W 16
`define CPC_MAG_W 16
`define CPC_PH_W 18
`define CPC_PH_FMT_W 16
`define CPC_ACC_W 20
`define CPC_CNT_W 5
`define CPC_FULL_CYCLES 5'h11
`define CPC_LAST_ITER 5'h0F
`define CPC_N_ITER 16
`define CPC_MAG_SHIFT 2
`define CPC_HALF_TURN 18'h2_0000
`define CPC_ACC_RST 20'h0_0000
`define CPC_PH_RST 18'h0_0000
`define CPC_MAG_RST 16'h0000
`define CPC_CNT_RST 5'h00

// arctan(2^-k) in 2^-18 turn units, truncated
`define CPC_ATAN_0 18'h0_8000
`define CPC_ATAN_1 18'h0_4B90
`define CPC_ATAN_2 18'h0_27EC
`define CPC_ATAN_3 18'h0_1444
`define CPC_ATAN_4 18'h0_0A2C
`define CPC_ATAN_5 18'h0_0517
`define CPC_ATAN_6 18'h0_028B
`define CPC_ATAN_7 18'h0_0145
`define CPC_ATAN_8 18'h0_00A2
`define CPC_ATAN_9 18'h0_0051
`define CPC_ATAN_10 18'h0_0028
`define CPC_ATAN_11 18'h0_0014
`define CPC_ATAN_12 18'h0_000A
`define CPC_ATAN_13 18'h0_0005
`define CPC_ATAN_14 18'h0_0002
`define CPC_ATAN_15 18'h0_0001

`endif

// [logic/cpc_pkg.sv]
// types shared by the cartesian to polar converter
`default_nettype none
`include "cpc_defs.svh"

package cpc_pkg;

  typedef logic signed [`CPC_IN_W-1:0] iq_t;

  typedef struct packed {
    iq_t in_i;
    iq_t in_q;
  } sample_s;

  typedef struct packed {
    logic [`CPC_MAG_W-1:0]   mag;
    logic [`CPC_PH_W-1:0]    phase;
    logic [`CPC_CNT_W-1:0]   depth;
  } polar_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } conv_state_e;

endpackage : cpc_pkg

`default_nettype wire

// [tb/cpc_src.sv]
// upstream sample source, launches i/q pairs off the falling edge
`timescale 1ns/1ps
`default_nettype none
module cpc_src
  import cpc_pkg::*;
(
  input  wire logic    mclk,
  input  wire logic    go,
  input  wire sample_s smp,
  output var  logic    in_valid,
  output var  sample_s in_sample
);
  initial begin
    in_valid  = 1'b0;
    in_sample = '0;
  end
  // between samples the bus flips every cycle, last word and its inverse in turn
  always @(negedge mclk) begin
    in_valid  <= go;
    in_sample <= go ? smp : ~in_sample;
  end
endmodule : cpc_src
`default_nettype wire

// [tb/cpc_sva.sv]
// assertion checker for the polar converter ports
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defs.svh"
module cpc_sva
  import cpc_pkg::*;
(
  input wire logic                     mclk,
  input wire logic                     rst_n,
  input wire logic                     in_valid,
  input wire sample_s                  in_sample,
  input wire polar_s                   result,
  input wire logic [`CPC_PH_FMT_W-1:0] phase_fmt,
  input wire logic                     result_valid
);
  logic [4:0] age_ff;
  logic [4:0] nxt_age;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // edges since the current sample was taken
  always_comb begin
    nxt_age = age_ff;
    if (in_valid) nxt_age = 5'h01;
    else if (age_ff == 5'h10) nxt_age = 5'h00;
    else if (age_ff != 5'h00) nxt_age = age_ff + 5'h01;
  end
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) age_ff <= 5'h00;
    else age_ff <= nxt_age;
  mag_msb_a: assert property (result.mag[15] == 1'b0)
    else $error("mag msb set");
  fmt_top_a: assert property (phase_fmt == result.phase[17:2])
    else $error("fmt phase wrong");
  full_time_a: assert property (age_ff == 5'h10 |=> result_valid && result.depth == 5'h11)
    else $error("full result late");
  partial_cap_a: assert property (in_valid && age_ff != 5'h00 && age_ff != 5'h10
    |=> result_valid && result.depth == $past(age_ff)) else $error("partial capture wrong");
  mid_run_a: assert property (!in_valid && age_ff != 5'h00 && age_ff != 5'h10 |=> !result_valid)
    else $error("early capture");
  idle_quiet_a: assert property (age_ff == 5'h00 |=> !result_valid)
    else $error("strobe while idle");
  hold_res_a: assert property (!result_valid |-> $stable(result))
    else $error("result moved");
  one_pulse_a: assert property (result_valid && !$past(in_valid) |=> !result_valid)
    else $error("strobe too long");
  cover property (age_ff == 5'h10);
  cover property (in_valid && age_ff == 5'h10);
  cover property (in_valid && age_ff == 5'h06);
  cover property (in_valid && age_ff == 5'h01);
endmodule : cpc_sva
`default_nettype wire

// [tb/tb.sv]
// testbench for the cartesian to polar converter
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cpc_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        go = 1'b0;
  logic        in_valid;
  logic        result_valid;
  sample_s     smp = '0;
  sample_s     in_sample;
  polar_s      result;
  logic [15:0] phase_fmt;
  int          failures = 0;
  int          checks_done = 0;
  always #2 mclk = ~mclk;
  cpc_src i_cpc_src(.mclk(mclk), .go(go), .smp(smp), .in_valid(in_valid), .in_sample(in_sample));
  cartesian_polar_converter i_cartesian_polar_converter(.mclk(mclk), .rst_n(rst_n), .in_valid(in_valid),
    .in_sample(in_sample), .result(result), .phase_fmt(phase_fmt), .result_valid(result_valid));
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic send(input sample_s s);
    @(posedge mclk);
    go  <= 1'b1;
    smp <= s;
    @(posedge mclk);
    go  <= 1'b0;
  endtask : send
  task automatic wait_res;
    @(negedge mclk);
    for (int i = 0; i < 40 && result_valid !== 1'b1; i++) @(negedge mclk);
    chk(result_valid, "no strobe");
  endtask : wait_res
  task automatic t_full;
    sample_s     v[5] = '{'{16'h4000, 16'h0000}, '{16'h0000, 16'h4000}, '{16'hC000, 16'h0000},
                          '{16'h0000, 16'hC000}, '{16'h2D41, 16'h2D41}};
    logic [17:0] ph[5] = '{18'h0_0000, 18'h1_0000, 18'h2_0000, 18'h3_0000, 18'h0_8000};
    logic [17:0] d;
    for (int k = 0; k < 5; k++) begin
      send(v[k]);
      wait_res();
      d = result.phase - ph[k];
      chk(result.depth === 5'h11, "not full depth");
      chk(d < 18'h0_0005 || d > 18'h3_FFFB, "phase off");
      chk(result.mag > 16'h1A51 && result.mag < 16'h1A61, "mag off");
      chk(result.mag[15] === 1'b0, "mag msb");
      chk(phase_fmt === result.phase[17:2], "fmt word");
    end
    $display("full precision test done");
  endtask : t_full
  task automatic t_partial;
    send('{16'h4000, 16'h0000});
    repeat (4) @(posedge mclk);
    send('{16'h0000, 16'h4000});
    wait_res();
    chk(result.depth === 5'h06, "partial depth");
    wait_res();
    chk(result.depth === 5'h11, "restart depth");
    $display("preempt test done");
  endtask : t_partial
  task automatic t_edge;
    logic [17:0] d;
    send('{16'h4000, 16'h0000});
    repeat (14) @(posedge mclk);
    send('{16'h0000, 16'hC000});
    wait_res();
    chk(result.depth === 5'h11, "edge full depth");
    wait_res();
    d = result.phase - 18'h3_0000;
    chk(result.depth === 5'h11, "edge next depth");
    chk(d < 18'h0_0005 || d > 18'h3_FFFB, "edge phase off");
    $display("coincident sample test done");
  endtask : t_edge
  task automatic t_b2b;
    @(posedge mclk);
    go  <= 1'b1;
    smp <= '{16'h4000, 16'h0000};
    @(posedge mclk);
    smp <= '{16'h0000, 16'h4000};
    @(posedge mclk);
    smp <= '{16'hC000, 16'h0000};
    @(negedge mclk);
    chk(result_valid === 1'b1 && result.depth === 5'h01, "b2b first");
    @(posedge mclk);
    go <= 1'b0;
    @(negedge mclk);
    chk(result_valid === 1'b1 && result.depth === 5'h01, "b2b second");
    wait_res();
    chk(result.depth === 5'h11, "b2b last");
    $display("back to back test done");
  endtask : t_b2b
  initial begin
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    chk(result === '0 && phase_fmt === '0 && result_valid === 1'b0, "reset value");
    t_full();
    t_partial();
    t_b2b();
    t_edge();
    stop_test();
  end
  initial begin
    #(4 * 2000);
    failures++;
    stop_test();
  end
endmodule : tb
bind cartesian_polar_converter cpc_sva i_cpc_sva(.mclk(mclk), .rst_n(rst_n), .in_valid(in_valid),
  .in_sample(in_sample), .result(result), .phase_fmt(phase_fmt), .result_valid(result_valid));
`default_nettype wire
